// file: core/rcc_top.sv
// Response cycle calculator with AHB-Lite register access
`timescale 1ns/1ps
module rcc_top
   import rcc_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Events
   output logic             result_valid,
   output logic             irq
);

   // Configuration and node table
   logic [2:0]  cfg_mode_reg;
   logic        cfg_size_reg;
   logic [4:0]  cfg_nodes_reg;
   logic [2:0]  cfg_extra_reg;
   logic [31:0] node_mem [RCC_MAX_NODES];
   // Sequencer
   logic               busy_reg;
   logic [3:0]         idx_reg;
   logic [7:0]         offs_reg;
   logic signed [19:0] lo_reg;
   logic signed [19:0] hi_reg;
   // Results
   logic signed [19:0] lo_out_reg;
   logic signed [19:0] hi_out_reg;
   logic signed [19:0] main_reg;
   logic               infeas_reg;
   logic               valid_reg;
   logic [1:0]         irq_stat_reg;
   logic [1:0]         irq_en_reg;
   // Bus data phase
   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;

   function automatic logic [7:0] resp_offset(input logic [2:0] mode, input logic size16);
      if (mode == 3'h0 && size16)
         return RCC_OFFS_SMALL;
      else if ((mode == 3'h0 && !size16) || (mode == 3'h1 && size16))
         return RCC_OFFS_MID;
      else
         return RCC_OFFS_LARGE;
   endfunction : resp_offset

   function automatic logic [5:0] chan_count(input logic [2:0] mode);
      case (mode)
         3'h0:    return 6'h02;
         3'h1:    return 6'h04;
         3'h2:    return 6'h08;
         3'h3:    return 6'h0C;
         3'h4:    return 6'h10;
         3'h5:    return 6'h14;
         3'h6:    return 6'h18;
         default: return 6'h20;
      endcase
   endfunction : chan_count

   function automatic logic signed [19:0] activity(input logic [7:0] cnt, input logic [7:0] w,
                                                   input logic [2:0] extra);
      logic [16:0] p;
      p = {9'h0, cnt} * ({9'h0, w} + {14'h0, extra});
      return signed'({3'h0, p});
   endfunction : activity

   function automatic logic signed [19:0] ceil4(input logic signed [19:0] x);
      return (x + RCC_CEIL_ADD) >>> 2;
   endfunction : ceil4

   // Per-node limits for the node under work
   logic [31:0]        entry;
   logic signed [19:0] dn_lim;
   logic signed [19:0] up_lim;
   logic signed [19:0] lo_new;
   logic signed [19:0] hi_new;
   logic               last_node;
   logic               start_req;
   logic               start_go;

   assign entry  = node_mem[idx_reg];
   assign dn_lim = ceil4(RCC_FRAME_BITS + activity(entry[RCC_DN_CNT_LSB +: 8], entry[RCC_DN_W_LSB +: 8],
                   cfg_extra_reg)) + signed'({14'h0, idx_reg, 2'b00}) + RCC_DN_MARGIN;
   // Ceiling of offset minus a quarter is offset minus floor of the quarter
   assign up_lim = signed'({12'h0, offs_reg}) - RCC_UP_MARGIN - ((RCC_FRAME_BITS
                   + activity(entry[RCC_UP_CNT_LSB +: 8], entry[RCC_UP_W_LSB +: 8], cfg_extra_reg)) >>> 2);
   assign lo_new    = (dn_lim > lo_reg) ? dn_lim : lo_reg;
   assign hi_new    = (up_lim < hi_reg) ? up_lim : hi_reg;
   assign last_node = ({1'b0, idx_reg} == cfg_nodes_reg - 5'h1);

   // Bus address phase
   logic       addr_ok;
   logic [7:0] a_off;
   assign addr_ok   = hsel && hready && (htrans == RCC_HTRANS_NONSEQ);
   assign a_off     = {haddr[7:2], 2'b00};
   assign hreadyout = 1'b1;
   assign hresp     = RCC_HRESP_OKAY;

   assign start_req = wr_pend_reg && wr_addr_reg == RCC_CTRL_OFF && hwdata[0];
   assign start_go  = start_req && !busy_reg && cfg_nodes_reg != 5'h0
                      && cfg_nodes_reg <= 5'(RCC_MAX_NODES);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= a_off;
      end
   end

   // Configuration writes, refused while busy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_mode_reg  <= 3'h0;
         cfg_size_reg  <= RCC_SIZE_RESET;
         cfg_nodes_reg <= RCC_NODES_RESET;
         cfg_extra_reg <= RCC_EXTRA_RESET;
      end else if (wr_pend_reg && !busy_reg && wr_addr_reg == RCC_CONFIG_OFF) begin
         cfg_mode_reg  <= hwdata[RCC_CFG_MODE_LSB +: 3];
         cfg_size_reg  <= hwdata[RCC_CFG_SIZE_BIT];
         cfg_nodes_reg <= hwdata[RCC_CFG_NODES_LSB +: 5];
         cfg_extra_reg <= hwdata[RCC_CFG_EXTRA_LSB +: 3];
      end
   end

   always_ff @(posedge hclk) begin
      if (wr_pend_reg && !busy_reg && wr_addr_reg[7:6] == RCC_NODE_PAGE)
         node_mem[wr_addr_reg[5:2]] <= hwdata;
   end

   // Node sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         idx_reg  <= 4'h0;
         offs_reg <= RCC_OFFS_LARGE;
         lo_reg   <= RCC_LO_INIT;
         hi_reg   <= RCC_HI_INIT;
      end else if (start_go) begin
         busy_reg <= 1'b1;
         idx_reg  <= 4'h0;
         offs_reg <= resp_offset(cfg_mode_reg, cfg_size_reg);
         lo_reg   <= RCC_LO_INIT;
         hi_reg   <= RCC_HI_INIT;
      end else if (busy_reg) begin
         lo_reg  <= lo_new;
         hi_reg  <= hi_new;
         idx_reg <= idx_reg + 4'h1;
         if (last_node)
            busy_reg <= 1'b0;
      end
   end

   // Results, held until the next finish
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lo_out_reg <= 20'sh0;
         hi_out_reg <= 20'sh0;
         main_reg   <= 20'sh0;
         infeas_reg <= 1'b0;
         valid_reg  <= 1'b0;
      end else begin
         valid_reg <= busy_reg && last_node;
         if (busy_reg && last_node) begin
            lo_out_reg <= lo_new;
            hi_out_reg <= hi_new;
            main_reg   <= (lo_new + hi_new) >>> 1;
            infeas_reg <= lo_new > hi_new;
         end
      end
   end
   assign result_valid = valid_reg;

   // Interrupts
   logic [1:0] ev;
   assign ev = {valid_reg && infeas_reg, valid_reg};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 2'h0;
         irq_en_reg   <= 2'h0;
      end else begin
         if (wr_pend_reg && wr_addr_reg == RCC_IRQ_EN_OFF)
            irq_en_reg <= hwdata[1:0];
         if (wr_pend_reg && wr_addr_reg == RCC_IRQ_CLR_OFF)
            irq_stat_reg <= (irq_stat_reg & ~hwdata[1:0]) | ev;
         else
            irq_stat_reg <= irq_stat_reg | ev;
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // Read data, prepared in the address phase
   logic [31:0]        rd_next;
   logic signed [19:0] sub_val;
   assign sub_val = main_reg - signed'({14'h0, a_off[5:2], 2'b00});
   always_comb begin
      rd_next = 32'h0;
      if (a_off[7:6] == RCC_NODE_PAGE)
         rd_next = node_mem[a_off[5:2]];
      else if (a_off[7:6] == RCC_SUB_PAGE)
         rd_next = {{12{sub_val[19]}}, sub_val};
      else begin
         case (a_off)
            RCC_CONFIG_OFF:   rd_next = {20'h0, cfg_extra_reg, cfg_nodes_reg, cfg_size_reg, cfg_mode_reg};
            RCC_STATUS_OFF:   rd_next = {16'h0, 2'h0, chan_count(cfg_mode_reg), offs_reg[7:0]}
                                        | {29'h0, infeas_reg, 1'b0, busy_reg} << 16;
            RCC_RESULT_OFF:   rd_next = {{12{main_reg[19]}}, main_reg};
            RCC_LIMITS_OFF:   rd_next = {lo_out_reg[15:0], hi_out_reg[15:0]};
            RCC_IRQ_STAT_OFF: rd_next = {30'h0, irq_stat_reg};
            RCC_IRQ_EN_OFF:   rd_next = {30'h0, irq_en_reg};
            default:          rd_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (addr_ok && !hwrite)
         hrdata <= rd_next;
   end

   // Cycles spent in the current run
   logic [4:0] run_len_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         run_len_reg <= 5'h0;
      else if (start_go)
         run_len_reg <= 5'h0;
      else if (busy_reg)
         run_len_reg <= run_len_reg + 5'h1;
   end

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_offset_two: assert property (busy_reg && cfg_mode_reg == 3'h0 && cfg_size_reg |-> offs_reg == 8'hEE)
      else $error("offset for two channels 16 bit wrong");
   chk_offset_wide: assert property (busy_reg && cfg_mode_reg >= 3'h2 |-> offs_reg == 8'hF8)
      else $error("offset for wide mode wrong");
   chk_valid_pulse: assert property (valid_reg |=> !valid_reg)
      else $error("valid longer than one cycle");
   chk_result_hold: assert property (!busy_reg |=> $stable(main_reg) && $stable(infeas_reg))
      else $error("result changed while idle");
   chk_infeas_flag: assert property (valid_reg |-> infeas_reg == (lo_out_reg > hi_out_reg))
      else $error("infeasible flag wrong");
   chk_main_avg: assert property (valid_reg |-> main_reg == ((lo_out_reg + hi_out_reg) >>> 1))
      else $error("main value not the average");
   chk_lo_rise: assert property (busy_reg && !start_go |=> lo_reg >= $past(lo_reg))
      else $error("minimum decreased");
   chk_hi_fall: assert property (busy_reg && !start_go |=> hi_reg <= $past(hi_reg))
      else $error("maximum increased");
   chk_done_irq: assert property (valid_reg |=> irq_stat_reg[RCC_IRQ_DONE])
      else $error("done status not set");
   chk_single_node: assert property (start_go && cfg_nodes_reg == 5'h1 |=> busy_reg ##1 valid_reg)
      else $error("single node run length wrong");

   // Offset choice
   chk_offset_mid: assert property (busy_reg && ((cfg_mode_reg == 3'h0 && !cfg_size_reg)
                                    || (cfg_mode_reg == 3'h1 && cfg_size_reg)) |-> offs_reg == 8'hF5)
      else $error("offset for mid modes wrong");
   chk_offset_four: assert property (busy_reg && cfg_mode_reg == 3'h1 && !cfg_size_reg
                                     |-> offs_reg == 8'hF8)
      else $error("offset for four channels 32 bit wrong");
   chk_offs_range: assert property (busy_reg |-> offs_reg inside {8'hEE, 8'hF5, 8'hF8})
      else $error("offset outside the table");
   chk_offs_hold: assert property (!start_go |=> $stable(offs_reg))
      else $error("offset changed without a start");

   // Sequencer
   chk_cfg_frozen: assert property (busy_reg |=> $stable(cfg_mode_reg) && $stable(cfg_size_reg)
                                    && $stable(cfg_nodes_reg) && $stable(cfg_extra_reg))
      else $error("configuration changed during a run");
   chk_cfg_write: assert property (wr_pend_reg && !busy_reg && wr_addr_reg == RCC_CONFIG_OFF
                                   |=> cfg_mode_reg == $past(hwdata[RCC_CFG_MODE_LSB +: 3]))
      else $error("mode field not taken");
   chk_seq_init: assert property (start_go |=> busy_reg && idx_reg == 4'h0 && lo_reg == RCC_LO_INIT
                                  && hi_reg == RCC_HI_INIT)
      else $error("run did not start cleanly");
   chk_start_refused: assert property (start_req && busy_reg && !last_node
                                       |=> busy_reg && idx_reg == $past(idx_reg) + 4'h1)
      else $error("start while busy disturbed the run");
   chk_idx_range: assert property (busy_reg |-> {1'b0, idx_reg} < cfg_nodes_reg)
      else $error("node index beyond node count");
   chk_last_valid: assert property (busy_reg && last_node |=> valid_reg && !busy_reg)
      else $error("last node did not finish the run");
   chk_valid_after: assert property (valid_reg |-> $past(busy_reg) && !busy_reg)
      else $error("valid without a finished run");
   chk_run_length: assert property (valid_reg |-> run_len_reg == cfg_nodes_reg)
      else $error("run length differs from node count");
   chk_dn_floor: assert property (busy_reg |-> dn_lim >= signed'({14'h0, idx_reg, 2'b00}) + 20'sh12)
      else $error("lower limit below its floor");
   chk_up_cap: assert property (busy_reg |-> up_lim <= signed'({12'h0, offs_reg}) - 20'sh11)
      else $error("upper limit above its cap");

   // Results and interrupts
   chk_main_between: assert property (valid_reg && !infeas_reg
                                      |-> main_reg >= lo_out_reg && main_reg <= hi_out_reg)
      else $error("main value outside the limits");
   chk_limits_hold: assert property (!busy_reg |=> $stable(lo_out_reg) && $stable(hi_out_reg))
      else $error("limits changed while idle");
   chk_infeas_irq: assert property (valid_reg && infeas_reg |=> irq_stat_reg[RCC_IRQ_INFEAS])
      else $error("infeasible status not set");
   chk_irq_clear: assert property (wr_pend_reg && wr_addr_reg == RCC_IRQ_CLR_OFF && hwdata[RCC_IRQ_DONE]
                                   && !valid_reg |=> !irq_stat_reg[RCC_IRQ_DONE])
      else $error("done status not cleared");

   // Read data
   chk_result_read: assert property (addr_ok && !hwrite && a_off == RCC_RESULT_OFF
                                     |=> hrdata[19:0] == $past(main_reg))
      else $error("result read back wrong");
   chk_limits_read: assert property (addr_ok && !hwrite && a_off == RCC_LIMITS_OFF
                                     |=> hrdata == {$past(lo_out_reg[15:0]), $past(hi_out_reg[15:0])})
      else $error("limits read back wrong");
   chk_status_offs: assert property (addr_ok && !hwrite && a_off == RCC_STATUS_OFF
                                     |=> hrdata[7:0] == $past(offs_reg))
      else $error("status offset field wrong");
   chk_chan_decode: assert property (addr_ok && !hwrite && a_off == RCC_STATUS_OFF && cfg_mode_reg == 3'h7
                                     |=> hrdata[13:8] == 6'h20)
      else $error("channel count decode wrong");
   chk_sub_read: assert property (addr_ok && !hwrite && a_off[7:6] == RCC_SUB_PAGE && !busy_reg
                                  |=> hrdata[19:0] == main_reg - {14'h0, $past(a_off[5:2]), 2'b00})
      else $error("subordinate value wrong");
   chk_hrdata_hold: assert property (!(addr_ok && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");

   cov_done:      cover property (valid_reg);
   cov_infeas:    cover property (valid_reg && infeas_reg);
   cov_busy_start: cover property (start_req && busy_reg);
   cov_irq:       cover property (irq);
   cov_sixteen:   cover property (valid_reg && cfg_nodes_reg == 5'h10);

endmodule : rcc_top

// file: shared/rcc_pkg.sv
// Constants and register map of the response cycle calculator
// What this block does
// - Result times last response after control frame
// - Upstream neighbour's value covers a silent last
// - Offset leaves processing time before serial output
// - Offset 238 or 245 for small modes, 248 for four channels at 32 bit
// - Offset 248 for larger modes
// - Decode mode to channels, size select
// - Activity is slot count times width plus extra
// - Extra bits per slot follow slot format
// - Lower limit ceil((64+down)/4)+4n+2
// - Upper limit offset minus ((64+up)/4+1), ceiling
// - Minimum is max lower, maximum min upper
// - Flag infeasible when minimum exceeds maximum
// - Main value is floor of average
// - Subordinate value is main minus 4n
package rcc_pkg;
   // Register byte offsets
   localparam logic [7:0] RCC_CTRL_OFF     = 8'h00;
   localparam logic [7:0] RCC_CONFIG_OFF   = 8'h04;
   localparam logic [7:0] RCC_STATUS_OFF   = 8'h08;
   localparam logic [7:0] RCC_RESULT_OFF   = 8'h0C;
   localparam logic [7:0] RCC_LIMITS_OFF   = 8'h10;
   localparam logic [7:0] RCC_IRQ_STAT_OFF = 8'h14;
   localparam logic [7:0] RCC_IRQ_CLR_OFF  = 8'h18;
   localparam logic [7:0] RCC_IRQ_EN_OFF   = 8'h1C;
   localparam logic [1:0] RCC_NODE_PAGE    = 2'h1;
   localparam logic [1:0] RCC_SUB_PAGE     = 2'h2;
   // Config fields
   localparam int RCC_CFG_MODE_LSB  = 0;
   localparam int RCC_CFG_SIZE_BIT  = 3;
   localparam int RCC_CFG_NODES_LSB = 4;
   localparam int RCC_CFG_EXTRA_LSB = 9;
   localparam logic [2:0] RCC_EXTRA_RESET = 3'h1;
   localparam logic [4:0] RCC_NODES_RESET = 5'h1;
   localparam logic       RCC_SIZE_RESET  = 1'b1;
   // Node table entry fields
   localparam int RCC_DN_CNT_LSB = 0;
   localparam int RCC_DN_W_LSB   = 8;
   localparam int RCC_UP_CNT_LSB = 16;
   localparam int RCC_UP_W_LSB   = 24;
   localparam int RCC_MAX_NODES  = 16;
   // Interrupt bits
   localparam int RCC_IRQ_DONE   = 0;
   localparam int RCC_IRQ_INFEAS = 1;
   // Offsets and arithmetic constants
   localparam logic [7:0]         RCC_OFFS_SMALL = 8'hEE;
   localparam logic [7:0]         RCC_OFFS_MID   = 8'hF5;
   localparam logic [7:0]         RCC_OFFS_LARGE = 8'hF8;
   localparam logic signed [19:0] RCC_FRAME_BITS = 20'sh40;
   localparam logic signed [19:0] RCC_DN_MARGIN  = 20'sh2;
   localparam logic signed [19:0] RCC_UP_MARGIN  = 20'sh1;
   localparam logic signed [19:0] RCC_CEIL_ADD   = 20'sh3;
   localparam logic signed [19:0] RCC_LO_INIT    = 20'sh80000;
   localparam logic signed [19:0] RCC_HI_INIT    = 20'sh7FFFF;
   // AHB encodings
   localparam logic [1:0] RCC_HTRANS_NONSEQ = 2'h2;
   localparam logic       RCC_HRESP_OKAY    = 1'b0;
endpackage : rcc_pkg

// file: sim/tb.sv
// Self-checking testbench for the response cycle calculator
`timescale 1ns/1ps
module tb import rcc_pkg::*;;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hready, hreadyout, hresp, result_valid, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        rd_phase, m_inf;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          seed = 32'hA923C797;
   int          st_cyc, m_off, m_lo, m_hi, m_main, irq_en, nn, ex;
   logic [31:0] rd_q[$];
   int          lat_q[$];
   logic [7:0]  dc[16], dw[16], uc[16], uw[16];
   int          ch_tab[8] = '{2, 4, 8, 12, 16, 20, 24, 32};

   rcc_top u_rcc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .result_valid(result_valid), .irq(irq));
   assign hready = hreadyout;

   always #2 hclk = ~hclk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // Result monitor
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (rd_phase && hready) chk("hrdata", rd_q.pop_front(), hrdata);
      if (result_valid === 1'b1) begin
         if (lat_q.size() == 0) chk("extra result_valid", 32'h0, 32'h1);
         else chk("result latency", 32'(lat_q.pop_front()), 32'(cyc - st_cyc));
      end
   end

   task automatic wait_rdy;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (i == 50) begin
         n_fail++;
         summarize();
      end
   endtask : wait_rdy

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      htrans <= RCC_HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rd_phase <= ~wr;
      wait_rdy();
      rd_phase <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   // Reference arithmetic
   function automatic void calc(input int mode, input int size);
      int lo, hi;
      m_off = (mode == 0) ? (size != 0 ? 238 : 245) : (mode == 1 && size != 0) ? 245 : 248;
      m_lo = -100000;
      m_hi = 100000;
      for (int n = 0; n < nn; n++) begin
         lo = (64 + dc[n] * (dw[n] + ex) + 3) / 4 + 4 * n + 2;
         hi = m_off - 1 - (64 + uc[n] * (uw[n] + ex)) / 4;
         if (lo > m_lo) m_lo = lo;
         if (hi < m_hi) m_hi = hi;
      end
      m_inf = m_lo > m_hi;
      m_main = (m_lo + m_hi) >>> 1;
   endfunction : calc

   // One full calculation with readback
   task automatic run(input int mode, input int size, input bit dbl);
      int i;
      calc(mode, size);
      xfer(1'b1, 32'(RCC_CONFIG_OFF), 32'(ex << 9 | nn << 4 | size << 3 | mode));
      for (int n = 0; n < nn; n++) xfer(1'b1, 32'h40 + 32'(4 * n), {uw[n], uc[n], dw[n], dc[n]});
      lat_q.push_back(nn + 1);
      xfer(1'b1, 32'(RCC_CTRL_OFF), 32'h1);
      st_cyc = cyc;
      if (dbl) xfer(1'b1, 32'(RCC_CTRL_OFF), 32'h1);
      for (i = 0; i < 100; i++) begin
         @(posedge hclk);
         if (result_valid === 1'b1) break;
      end
      if (i == 100) begin
         n_fail++;
         summarize();
      end
      @(posedge hclk);
      chk("irq", 32'((irq_en & (m_inf ? 3 : 1)) != 0), 32'(irq));
      rd(32'(RCC_STATUS_OFF), 32'(m_off | ch_tab[mode] << 8 | int'(m_inf) << 18));
      rd(32'(RCC_RESULT_OFF), 32'(m_main));
      rd(32'(RCC_LIMITS_OFF), {16'(m_lo), 16'(m_hi)});
      for (int n = 0; n < nn; n++) rd(32'h80 + 32'(4 * n), 32'(m_main - 4 * n));
      rd(32'(RCC_IRQ_STAT_OFF), {30'h0, m_inf, 1'b1});
      xfer(1'b1, 32'(RCC_IRQ_CLR_OFF), 32'h3);
      @(posedge hclk);
      chk("irq cleared", 32'h0, 32'(irq));
   endtask : run

   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rd_phase = 1'b0;
      irq_en = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and unmapped space
      rd(32'(RCC_CONFIG_OFF), 32'h0000_0218);
      xfer(1'b1, 32'h20, 32'hFFFF_FFFF);
      rd(32'h20, 32'h0);
      // Offset table over every mode and size
      {dc[0], dw[0], uc[0], uw[0]} = 32'h0;
      nn = 1;
      ex = 1;
      for (int m = 0; m < 16; m++) run(m >> 1, m & 1, 1'b0);
      // Two-node reference system
      {uw[0], uc[0], dw[0], dc[0]} = 32'h100C_180E;
      {uw[1], uc[1], dw[1], dc[1]} = 32'h100A_1810;
      irq_en = 3;
      xfer(1'b1, 32'(RCC_IRQ_EN_OFF), 32'h3);
      rd(32'(RCC_IRQ_EN_OFF), 32'h3);
      nn = 2;
      run(2, 0, 1'b0);
      // Random configurations, restart while busy, masking
      for (int it = 0; it < 6; it++) begin
         nn = (it == 0) ? 16 : ($random(seed) & 15) + 1;
         for (int n = 0; n < 16; n++) begin
            {uw[n], uc[n], dw[n], dc[n]} = $random(seed) & ((it & 1) ? 32'h0F0F_0F0F : 32'hFFFF_FFFF);
         end
         ex = $random(seed) & 7;
         irq_en = $random(seed) & 3;
         xfer(1'b1, 32'(RCC_IRQ_EN_OFF), 32'(irq_en));
         run($random(seed) & 7, $random(seed) & 1, it == 0);
      end
      repeat (20) @(posedge hclk);
      summarize();
   end
endmodule : tb
